// File: rtl/sdpwm_core.sv
// Purpose: six-mode dual-output pulse-width modulator with sigma-delta modes
// Assumes: byte-wide register port on ref_clk; oscillator is ref_clk itself
// Notes:   all outputs come from the state register
//
// What this block does
// - any control register write clears the modulator counter
// - in 16-bit modes a low byte write goes to a hidden holding byte
// - high byte write loads full value; outputs switch at next cycle start
// - mode field bits 6..4 select one of six modes or disabled
// - prescale field bits 3..2 divides counter clock by 1, 4, 16, 64
// - clock source bits 1..0: divided/15, divided, external pin, oscillator
// - control bit 7 turns off first output, freeing its pin
// - outputs routed to primary or alternate pin pair by configuration bit
// - four data bytes set the duty cycles of both outputs
// - sigma-delta modes give density-modulated output up to sixteen bits
// - single mode: channel 1 sets period, channel 0 sets duty
// - twin 8-bit: out0 falls at low match, out1 between high matches
// - twin 16-bit: full range count, high below value, rise at rollover
// - NRZ mode: high exactly programmed count of every 65536 clocks
`timescale 1ns/1ps
`default_nettype none
`include "sdpwm_defines.svh"

module sdpwm_core (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_n,
    input  wire sdpwm_pkg::sdpwm_sfr_req_t sfr_req,
    output logic [7:0]                  sfr_rdata,
    input  wire logic                   chip_configuration,
    input  wire logic [2:0]             divide_select,
    input  wire logic                   timer_zero_input,
    output var sdpwm_pkg::sdpwm_pins_t  pins
);

    sdpwm_pkg::sdpwm_state_t q;
    sdpwm_pkg::sdpwm_state_t d;

    logic        ext_rise;
    logic [12:0] divf_last;
    logic        div_tick;
    logic        d15_tick;
    logic        src_tick;
    logic [5:0]  pre_mask;
    logic        run;
    logic        is16;
    logic        mod_tick;
    logic [15:0] last;
    logic        wrap;
    logic [16:0] sum0;
    logic [16:0] sum1;
    logic        ch0;
    logic        ch1;
    logic        drive0;
    logic        drive1;

    always_comb begin
        d = q;
        ext_rise = 1'b0;
        ch0 = 1'b0;
        ch1 = 1'b0;

        // pin is asynchronous to ref_clk
        d.t0_s1 = timer_zero_input;
        d.t0_s2 = q.t0_s1;
        d.t0_prev = q.t0_s2;
        ext_rise = q.t0_s2 & ~q.t0_prev;

        divf_last = 13'((`SDPWM_DIVF_BASE << divide_select) - `SDPWM_DIVF_ONE);
        div_tick = (q.div_cnt >= divf_last);
        d.div_cnt = div_tick ? 13'h0000 : 13'(q.div_cnt + `SDPWM_DIVF_ONE);
        d15_tick = div_tick & (q.d15_cnt == `SDPWM_DIV15_LAST);
        if (div_tick) begin
            d.d15_cnt = d15_tick ? 4'h0 : 4'(q.d15_cnt + 4'h1);
        end

        case (q.ctrl.clock_source)
            `SDPWM_SRC_DIV15: src_tick = d15_tick;
            `SDPWM_SRC_DIV:   src_tick = div_tick;
            `SDPWM_SRC_EXT:   src_tick = ext_rise;
            default:          src_tick = 1'b1;
        endcase

        case (q.ctrl.prescale)
            `SDPWM_PRE_1:  pre_mask = `SDPWM_PMASK_1;
            `SDPWM_PRE_4:  pre_mask = `SDPWM_PMASK_4;
            `SDPWM_PRE_16: pre_mask = `SDPWM_PMASK_16;
            default:       pre_mask = `SDPWM_PMASK_64;
        endcase

        // reserved mode is treated as disabled
        run = (q.ctrl.op_select != `SDPWM_MODE_OFF) && (q.ctrl.op_select != `SDPWM_MODE_RSVD);
        is16 = (q.ctrl.op_select == `SDPWM_MODE_SINGLE) || (q.ctrl.op_select == `SDPWM_MODE_TWIN16)
            || (q.ctrl.op_select == `SDPWM_MODE_NRZ) || (q.ctrl.op_select == `SDPWM_MODE_RZ);
        mod_tick = run & src_tick & (q.pre_cnt == pre_mask);
        if (run & src_tick) begin
            d.pre_cnt = (q.pre_cnt == pre_mask) ? 6'h00 : 6'(q.pre_cnt + 6'h01);
        end

        case (q.ctrl.op_select)
            `SDPWM_MODE_SINGLE: last = 16'(q.act1 - `SDPWM_ONE16);
            `SDPWM_MODE_TWIN8:  last = {`SDPWM_ZERO8, q.c1l};
            `SDPWM_MODE_DUAL8:  last = {`SDPWM_ZERO8, q.c1l};
            default:            last = `SDPWM_CNT_LAST;
        endcase
        wrap = (q.cnt >= last);

        sum0 = {1'b0, q.acc0} + {1'b0, q.act0};
        sum1 = {1'b0, q.acc1} + {1'b0, q.act1};

        if (mod_tick) begin
            d.cnt = wrap ? `SDPWM_ZERO16 : 16'(q.cnt + `SDPWM_ONE16);
            d.cnt_b = (q.cnt_b >= q.c1h) ? `SDPWM_ZERO8 : 8'(q.cnt_b + `SDPWM_ONE8);
            // carry out gives exactly act ones per 65536 steps
            d.acc0 = sum0[15:0];
            d.acc1 = sum1[15:0];
            d.bit0 = sum0[16];
            d.bit1 = sum1[16];
            if (wrap) begin
                d.act0 = {q.c0h, q.c0l};
                d.act1 = {q.c1h, q.c1l};
            end
        end
        if (!run) begin
            // idle: first cycle after start uses the current data
            d.act0 = {q.c0h, q.c0l};
            d.act1 = {q.c1h, q.c1l};
        end

        case (q.ctrl.op_select)
            `SDPWM_MODE_SINGLE: begin
                ch1 = (q.cnt < q.act0);
            end
            `SDPWM_MODE_TWIN8: begin
                ch0 = (q.cnt[7:0] < q.c0l);
                // assumes rise byte not above fall byte
                ch1 = (q.cnt[7:0] >= q.c1h) && (q.cnt[7:0] < q.c0h);
            end
            `SDPWM_MODE_TWIN16: begin
                ch0 = (q.cnt < q.act0);
                ch1 = (q.cnt < q.act1);
            end
            `SDPWM_MODE_NRZ: begin
                ch0 = q.bit0;
                ch1 = q.bit1;
            end
            `SDPWM_MODE_DUAL8: begin
                ch0 = (q.cnt[7:0] < q.c0l);
                ch1 = (q.cnt_b < q.c0h);
            end
            `SDPWM_MODE_RZ: begin
                // return to zero in second half of prescaled clock; no half at /1
                ch0 = q.bit0 & (q.pre_cnt <= (pre_mask >> 1));
                ch1 = q.bit1 & (q.pre_cnt <= (pre_mask >> 1));
            end
            default: begin
                ch0 = 1'b0;
                ch1 = 1'b0;
            end
        endcase

        drive0 = run && !q.ctrl.first_output_off && (q.ctrl.op_select != `SDPWM_MODE_SINGLE);
        drive1 = run;
        d.pins.primary_out_a = ch0 & drive0 & ~chip_configuration;
        d.pins.primary_out_b = ch1 & drive1 & ~chip_configuration;
        d.pins.alternate_out_a = ch0 & drive0 & chip_configuration;
        d.pins.alternate_out_b = ch1 & drive1 & chip_configuration;
        // enables low while the modulator owns the pin
        d.pins.primary_a_drive_n = ~(drive0 & ~chip_configuration);
        d.pins.primary_b_drive_n = ~(drive1 & ~chip_configuration);
        d.pins.alternate_a_drive_n = ~(drive0 & chip_configuration);
        d.pins.alternate_b_drive_n = ~(drive1 & chip_configuration);

        // register writes last so they override counting
        if (sfr_req.we) begin
            if (sfr_req.addr == `SDPWM_ADDR_CTRL) begin
                d.ctrl = sdpwm_pkg::sdpwm_ctrl_t'(sfr_req.wdata);
                d.cnt = `SDPWM_ZERO16;
                d.cnt_b = `SDPWM_ZERO8;
                d.pre_cnt = 6'h00;
                d.acc0 = `SDPWM_ZERO16;
                d.acc1 = `SDPWM_ZERO16;
            end else if (sfr_req.addr == `SDPWM_ADDR_C0L) begin
                if (is16) begin
                    d.hold0 = sfr_req.wdata;
                end else begin
                    d.c0l = sfr_req.wdata;
                end
            end else if (sfr_req.addr == `SDPWM_ADDR_C0H) begin
                d.c0h = sfr_req.wdata;
                if (is16) begin
                    d.c0l = q.hold0;
                end
            end else if (sfr_req.addr == `SDPWM_ADDR_C1L) begin
                if (is16) begin
                    d.hold1 = sfr_req.wdata;
                end else begin
                    d.c1l = sfr_req.wdata;
                end
            end else if (sfr_req.addr == `SDPWM_ADDR_C1H) begin
                d.c1h = sfr_req.wdata;
                if (is16) begin
                    d.c1l = q.hold1;
                end
            end
        end

        if (sfr_req.addr == `SDPWM_ADDR_CTRL) begin
            d.rdata = q.ctrl;
        end else if (sfr_req.addr == `SDPWM_ADDR_C0L) begin
            d.rdata = q.c0l;
        end else if (sfr_req.addr == `SDPWM_ADDR_C0H) begin
            d.rdata = q.c0h;
        end else if (sfr_req.addr == `SDPWM_ADDR_C1L) begin
            d.rdata = q.c1l;
        end else if (sfr_req.addr == `SDPWM_ADDR_C1H) begin
            d.rdata = q.c1h;
        end else begin
            d.rdata = `SDPWM_READ_NONE;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
            // pins stay free digital I/O through reset
            q.pins.primary_a_drive_n <= `SDPWM_OE_OFF;
            q.pins.primary_b_drive_n <= `SDPWM_OE_OFF;
            q.pins.alternate_a_drive_n <= `SDPWM_OE_OFF;
            q.pins.alternate_b_drive_n <= `SDPWM_OE_OFF;
        end else begin
            q <= d;
        end
    end

    assign sfr_rdata = q.rdata;
    assign pins = q.pins;

endmodule

`default_nettype wire

// File: rtl/sdpwm_defines.svh
// Purpose: named constants of the dual-output modulator
// Assumes: byte-wide special-function register port
// Notes:   addresses are byte addresses on that port
`ifndef SDPWM_DEFINES_SVH
`define SDPWM_DEFINES_SVH

`define SDPWM_ADDR_CTRL   8'hAE
`define SDPWM_ADDR_C0L    8'hB1
`define SDPWM_ADDR_C0H    8'hB2
`define SDPWM_ADDR_C1L    8'hB3
`define SDPWM_ADDR_C1H    8'hB4

`define SDPWM_CTRL_RST    8'h00
`define SDPWM_DATA_RST    8'h00
`define SDPWM_READ_NONE   8'h00

`define SDPWM_MODE_OFF    3'h0
`define SDPWM_MODE_SINGLE 3'h1
`define SDPWM_MODE_TWIN8  3'h2
`define SDPWM_MODE_TWIN16 3'h3
`define SDPWM_MODE_NRZ    3'h4
`define SDPWM_MODE_DUAL8  3'h5
`define SDPWM_MODE_RZ     3'h6
`define SDPWM_MODE_RSVD   3'h7

`define SDPWM_SRC_DIV15   2'h0
`define SDPWM_SRC_DIV     2'h1
`define SDPWM_SRC_EXT     2'h2
`define SDPWM_SRC_OSC     2'h3

`define SDPWM_PRE_1       2'h0
`define SDPWM_PRE_4       2'h1
`define SDPWM_PRE_16      2'h2
`define SDPWM_PRE_64      2'h3
`define SDPWM_PMASK_1     6'h00
`define SDPWM_PMASK_4     6'h03
`define SDPWM_PMASK_16    6'h0F
`define SDPWM_PMASK_64    6'h3F

`define SDPWM_DIVF_BASE   13'h0020
`define SDPWM_DIVF_ONE    13'h0001
`define SDPWM_DIV15_LAST  4'hE
`define SDPWM_CNT_LAST    16'hFFFF
`define SDPWM_ONE16       16'h0001
`define SDPWM_ZERO16      16'h0000
`define SDPWM_ZERO8       8'h00
`define SDPWM_ONE8        8'h01
`define SDPWM_OE_OFF      1'b1

`endif

// File: rtl/sdpwm_pkg.sv
// Purpose: types of the dual-output modulator
// Assumes: sdpwm_defines.svh holds the numbers
// Notes:   state of the core is one packed struct
`default_nettype none
package sdpwm_pkg;

    typedef struct packed {
        logic       first_output_off;
        logic [2:0] op_select;
        logic [1:0] prescale;
        logic [1:0] clock_source;
    } sdpwm_ctrl_t;

    typedef struct packed {
        logic       we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } sdpwm_sfr_req_t;

    typedef struct packed {
        logic primary_out_a;
        logic primary_out_b;
        logic alternate_out_a;
        logic alternate_out_b;
        logic primary_a_drive_n;
        logic primary_b_drive_n;
        logic alternate_a_drive_n;
        logic alternate_b_drive_n;
    } sdpwm_pins_t;

    typedef struct packed {
        sdpwm_ctrl_t  ctrl;
        logic [7:0]   c0h;
        logic [7:0]   c0l;
        logic [7:0]   c1h;
        logic [7:0]   c1l;
        logic [7:0]   hold0;
        logic [7:0]   hold1;
        logic [15:0]  act0;
        logic [15:0]  act1;
        logic [15:0]  cnt;
        logic [7:0]   cnt_b;
        logic [12:0]  div_cnt;
        logic [3:0]   d15_cnt;
        logic [5:0]   pre_cnt;
        logic [15:0]  acc0;
        logic [15:0]  acc1;
        logic         bit0;
        logic         bit1;
        logic         t0_s1;
        logic         t0_s2;
        logic         t0_prev;
        logic [7:0]   rdata;
        sdpwm_pins_t  pins;
    } sdpwm_state_t;

endpackage

`default_nettype wire

// File: dv/sdpwm_load.sv
// Purpose: load model on the modulator pins
// Assumes: undriven outputs read 0
// Notes: counts high cycles and rising edges
`timescale 1ns/1ps
`default_nettype none
module sdpwm_load (
    input  wire logic                   ref_clk,
    input  wire logic                   clr,
    input  wire sdpwm_pkg::sdpwm_pins_t pins,
    output logic [15:0]                 hi_a,
    output logic [15:0]                 hi_b,
    output logic [15:0]                 rise_a
);
    logic a, b, a_q;
    // either pin pair feeds the filter
    assign a = pins.primary_out_a | pins.alternate_out_a;
    assign b = pins.primary_out_b | pins.alternate_out_b;
    always_ff @(posedge ref_clk) begin
        a_q <= a;
        hi_a <= clr ? 16'h0000 : hi_a + 16'(a);
        hi_b <= clr ? 16'h0000 : hi_b + 16'(b);
        rise_a <= clr ? 16'h0000 : rise_a + 16'(a & ~a_q);
    end
endmodule
`default_nettype wire

// File: dv/sdpwm_core_sva.sv
// Purpose: port checks of the modulator
// Assumes: control shadowed from the write port
// Notes: bound into sdpwm_core
`timescale 1ns/1ps
`default_nettype none
`include "sdpwm_defines.svh"
module sdpwm_core_sva (
    input wire logic                      ref_clk,
    input wire logic                      rst_n,
    input wire sdpwm_pkg::sdpwm_sfr_req_t sfr_req,
    input wire logic [7:0]                sfr_rdata,
    input wire logic                      chip_configuration,
    input wire logic [2:0]                divide_select,
    input wire logic                      timer_zero_input,
    input wire sdpwm_pkg::sdpwm_pins_t    pins
);
    sdpwm_pkg::sdpwm_ctrl_t ctrl_q;
    logic                   t0_q;
    logic [3:0]             quiet_q;
    logic                   off;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    assign off = ctrl_q.op_select inside {`SDPWM_MODE_OFF, `SDPWM_MODE_RSVD};
    // quiet: cycles since any write or pin change
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= '0;
            t0_q <= 1'b0;
            quiet_q <= 4'h0;
        end else begin
            if (sfr_req.we && sfr_req.addr == `SDPWM_ADDR_CTRL)
                ctrl_q <= sdpwm_pkg::sdpwm_ctrl_t'(sfr_req.wdata);
            t0_q <= timer_zero_input;
            if (sfr_req.we || timer_zero_input != t0_q)
                quiet_q <= 4'h0;
            else if (quiet_q != 4'hF)
                quiet_q <= quiet_q + 4'h1;
        end
    end
    property p_rd_none;
        !(sfr_req.addr inside {[`SDPWM_ADDR_C0L:`SDPWM_ADDR_C1H], `SDPWM_ADDR_CTRL}) |=> sfr_rdata == 8'h00;
    endproperty
    a_rd_none: assert property (p_rd_none) else $error("unmapped read");
    property p_rd_ctrl;
        sfr_req.addr == `SDPWM_ADDR_CTRL && !sfr_req.we |=> sfr_rdata == ctrl_q;
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control readback");
    property p_idle;
        off [*3] |-> {pins.primary_a_drive_n, pins.primary_b_drive_n,
                      pins.alternate_a_drive_n, pins.alternate_b_drive_n} == 4'hF;
    endproperty
    a_idle: assert property (p_idle) else $error("drive while disabled");
    property p_pair;
        $stable(chip_configuration) |-> (chip_configuration ? pins.primary_a_drive_n & pins.primary_b_drive_n
                                          : pins.alternate_a_drive_n & pins.alternate_b_drive_n) == 1'b1;
    endproperty
    a_pair: assert property (p_pair) else $error("wrong pin pair");
    property p_first_off;
        ctrl_q.first_output_off [*3] |-> pins.primary_a_drive_n && pins.alternate_a_drive_n;
    endproperty
    a_first_off: assert property (p_first_off) else $error("first output driven");
    property p_drive_b;
        (!off && !chip_configuration) [*3] |-> !pins.primary_b_drive_n;
    endproperty
    a_drive_b: assert property (p_drive_b) else $error("second output idle");
    property p_single;
        (ctrl_q.op_select == `SDPWM_MODE_SINGLE) [*3] |-> pins.primary_a_drive_n && pins.alternate_a_drive_n;
    endproperty
    a_single: assert property (p_single) else $error("single mode drives a");
    property p_ext_hold;
        ctrl_q.clock_source == `SDPWM_SRC_EXT && quiet_q > 4'h9 |-> $stable(pins);
    endproperty
    a_ext_hold: assert property (p_ext_hold) else $error("moved without pin edge");
endmodule
bind sdpwm_core sdpwm_core_sva i_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .chip_configuration(chip_configuration), .divide_select(divide_select),
    .timer_zero_input(timer_zero_input), .pins(pins)
);
`default_nettype wire

// File: dv/sdpwm_core_tb.sv
// Purpose: register-level bench of the modulator
// Assumes: divide factor 32, one run at 64
// Notes: waveforms judged by the load model counts
`timescale 1ns/1ps
`default_nettype none
`include "sdpwm_defines.svh"
module sdpwm_core_tb;
    logic                      ref_clk = 1'b0;
    logic                      rst_n = 1'b0;
    sdpwm_pkg::sdpwm_sfr_req_t req = '0;
    logic [7:0]                rdata;
    logic                      cfg = 1'b0;
    logic                      t0 = 1'b0;
    logic [2:0]                div_sel = 3'h0;
    logic                      clr = 1'b0;
    sdpwm_pkg::sdpwm_pins_t    pins;
    logic [15:0]               hi_a, hi_b, rise_a;
    int                        n_errors = 0;
    int                        cmp_count = 0;
    int                        cyc = 0;
    logic [7:0]                regs [4] = '{`SDPWM_ADDR_C0L, `SDPWM_ADDR_C0H, `SDPWM_ADDR_C1L, `SDPWM_ADDR_C1H};
    // control code, expected out a periods in 3840 cycles
    logic [23:0]               tbl [7] = '{24'h5303C0, 24'h5700F0, 24'h5B003C, 24'h5F000F,
                                           24'h51001E, 24'h52001E, 24'h500002};
    sdpwm_core i_dut (
        .ref_clk(ref_clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdata),
        .chip_configuration(cfg), .divide_select(div_sel), .timer_zero_input(t0), .pins(pins)
    );
    sdpwm_load i_load (.ref_clk(ref_clk), .clr(clr), .pins(pins), .hi_a(hi_a), .hi_b(hi_b), .rise_a(rise_a));
    initial forever #4 ref_clk = ~ref_clk;
    task automatic tally_and_finish();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // slow pin leaves quiet gaps between edges
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc % 16 == 15)
            t0 <= ~t0;
        if (cyc == 90000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, a, d};
        @(posedge ref_clk);
        req.we <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req.addr <= a;
        @(posedge ref_clk);
        #1 chk({8'h00, rdata}, {8'h00, e});
    endtask
    task automatic ld(input logic [7:0] h0, input logic [7:0] l0, input logic [7:0] h1, input logic [7:0] l1);
        wr(`SDPWM_ADDR_C0L, l0);
        wr(`SDPWM_ADDR_C0H, h0);
        wr(`SDPWM_ADDR_C1L, l1);
        wr(`SDPWM_ADDR_C1H, h1);
    endtask
    // settle one window, then count over the next
    task automatic meas(input int w);
        repeat (w) @(posedge ref_clk);
        clr <= 1'b1;
        @(posedge ref_clk);
        clr <= 1'b0;
        repeat (w) @(posedge ref_clk);
        #1;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(`SDPWM_ADDR_CTRL, 8'h00);
        foreach (regs[i]) rd(regs[i], 8'h00);
        wr(8'hAF, 8'h5A);
        rd(8'hAF, 8'h00);
        ld(8'h00, 8'h03, 8'h00, 8'h08);
        wr(`SDPWM_ADDR_CTRL, 8'h13);
        meas(16);
        chk(hi_b, 16'h0006);
        chk(hi_a, 16'h0000);
        wr(`SDPWM_ADDR_C0L, 8'h05);
        rd(`SDPWM_ADDR_C0L, 8'h03);
        wr(`SDPWM_ADDR_C0H, 8'h00);
        rd(`SDPWM_ADDR_C0L, 8'h05);
        meas(16);
        chk(hi_b, 16'h000A);
        wr(`SDPWM_ADDR_CTRL, 8'h23);
        ld(8'h05, 8'h03, 8'h01, 8'h07);
        meas(16);
        chk(hi_a, 16'h0006);
        chk(hi_b, 16'h0008);
        wr(`SDPWM_ADDR_CTRL, 8'h53);
        ld(8'h01, 8'h01, 8'h01, 8'h03);
        // no table entry uses the reserved mode code
        foreach (tbl[i]) begin
            wr(`SDPWM_ADDR_CTRL, tbl[i][23:16]);
            meas(3840);
            chk(rise_a, tbl[i][15:0]);
        end
        // divide factor 64: four ticks of 64 cycles per period
        wr(`SDPWM_ADDR_CTRL, 8'h51);
        div_sel <= 3'h1;
        meas(3840);
        chk(rise_a, 16'h000F);
        wr(`SDPWM_ADDR_CTRL, 8'h00);
        ld(8'h01, 8'h00, 8'h00, 8'h60);
        // counter restarts at 0, window sees counts 64..127
        wr(`SDPWM_ADDR_CTRL, 8'h33);
        meas(64);
        chk(hi_a, 16'h0040);
        chk(hi_b, 16'h0020);
        wr(`SDPWM_ADDR_CTRL, 8'h00);
        ld(8'h40, 8'h00, 8'hC0, 8'h00);
        cfg <= 1'b1;
        wr(`SDPWM_ADDR_CTRL, 8'h43);
        meas(1024);
        chk(hi_a, 16'h0100);
        chk(hi_b, 16'h0300);
        wr(`SDPWM_ADDR_CTRL, 8'hE7);
        meas(1024);
        chk(hi_a, 16'h0000);
        chk(hi_b, 16'h0180);
        tally_and_finish();
    end
endmodule
`default_nettype wire
